/* File: logic/duc_consts.svh */
`ifndef DUC_CONSTS_SVH
`define DUC_CONSTS_SVH

`define DUC_CLK_PERIOD_NS 10
`define DUC_RESET_SEQ_US 300
`define DUC_RESET_SEQ_CYC ((`DUC_RESET_SEQ_US * 1000) / `DUC_CLK_PERIOD_NS)
`define DUC_RST_PULSE_NS 30
`define DUC_RST_PULSE_CYC ((`DUC_RST_PULSE_NS + `DUC_CLK_PERIOD_NS - 1) / `DUC_CLK_PERIOD_NS)
`define DUC_SLOT_NS 600
`define DUC_SLOT_CYC (`DUC_SLOT_NS / `DUC_CLK_PERIOD_NS)
`define DUC_TAIL_NS 300
`define DUC_TAIL_CYC (`DUC_TAIL_NS / `DUC_CLK_PERIOD_NS)
`define DUC_NUM_CH 16
`define DUC_DATA_W 16
`define DUC_INPUT_RST 16'h8000
`define DUC_GAIN_RST 16'hffff
`define DUC_TRIM_RST 16'h8000
`define DUC_SEL_RST 16'h0000

`endif

/* File: logic/duc_pkg.sv */
package duc_pkg;
    typedef enum logic [1:0] {
        DUC_WR_INPUT,
        DUC_WR_GAIN,
        DUC_WR_TRIM,
        DUC_WR_SEL
    } duc_wr_kind_t;

    typedef enum logic [1:0] {
        DUC_CH_ONE,
        DUC_CH_PAIR,
        DUC_CH_GROUP,
        DUC_CH_ALL
    } duc_ch_mode_t;
endpackage

/* File: logic/duc_link_if.sv */
`timescale 1ns/1ps
interface duc_link_if;
    logic reset_n;
    logic output_clear_n;
    logic load_outputs_n;
    logic busy_dev_oe_n;
    logic busy_host_oe_n;
    logic busy_n;
    assign busy_n = busy_dev_oe_n & busy_host_oe_n;

    modport dev (
        input reset_n,
        input output_clear_n,
        input load_outputs_n,
        input busy_n,
        output busy_dev_oe_n
    );
    modport host (
        output reset_n,
        output output_clear_n,
        output load_outputs_n,
        output busy_host_oe_n,
        input busy_n
    );
endinterface

/* File: logic/duc_device.sv */
// What this block does
// - reset rising edge restores register defaults
// - host avoids writes during reset sequence
// - outputs at ground until write plus load
// - 30 ns low pulse resets; falling edge inert
// - clear low grounds outputs, values resume
// - load ignored while clear low
// - clear leaves registers unchanged
// - host holds clear during span change
// - non-select write starts recalculation, busy held low
// - writes accepted while busy, no update
// - busy open-drain, shared across devices
// - load during busy stored, applied after
// - load held low updates each busy end
// - source-select write busies about 600 ns
// - busy lasts (channels+1)x600 ns + 300 ns
// - load copies selected computed register out
// - reload only changed computed registers
// - host finds both errors before trimming
// - host adds zero error, subtracts span
// - host raises reset early at power-up
// - select 0 takes A, 1 takes B
// - A/B recalc chosen by input or select bit
`timescale 1ns/1ps
`include "duc_consts.svh"
module duc_device #(
    parameter int NUM_CH = `DUC_NUM_CH,
    parameter int DATA_W = `DUC_DATA_W,
    parameter int RESET_SEQ_CYC = `DUC_RESET_SEQ_CYC
) (
    input wire logic core_clk_i, // system clock
    input wire logic nrst_i, // async reset, active low
    duc_link_if.dev link, // pins toward host
    input wire logic wr_valid_i, // register write strobe
    input wire duc_pkg::duc_wr_kind_t wr_kind_i, // which register kind
    input wire logic wr_ab_sel_i, // register-select bit for input/gain/trim
    input wire duc_pkg::duc_ch_mode_t wr_mode_i, // channel addressing mode
    input wire logic [3:0] wr_ch_i, // addressed channel
    input wire logic [DATA_W-1:0] wr_data_i, // write data
    output logic reset_busy_o, // reset sequence running
    output logic calc_busy_o, // own calculation running
    output logic [NUM_CH-1:0] out_grounded_o, // output at signal_ground_ref
    output logic [NUM_CH*DATA_W-1:0] out_code_o // output register contents
);
    import duc_pkg::*;

    localparam int SLOT = `DUC_SLOT_CYC;
    localparam int TAIL = `DUC_TAIL_CYC;
    localparam int BW = $clog2(18 * SLOT + TAIL + 1);

    logic [DATA_W-1:0] input_reg_a [NUM_CH];
    logic [DATA_W-1:0] input_reg_b [NUM_CH];
    logic [DATA_W-1:0] gain_a [NUM_CH];
    logic [DATA_W-1:0] gain_b [NUM_CH];
    logic [DATA_W-1:0] trim_a [NUM_CH];
    logic [DATA_W-1:0] trim_b [NUM_CH];
    logic [DATA_W-1:0] computed_reg_a [NUM_CH];
    logic [DATA_W-1:0] computed_reg_b [NUM_CH];
    logic [DATA_W-1:0] out_q [NUM_CH];
    logic [NUM_CH-1:0] src_sel_q;
    logic [NUM_CH-1:0] dirty_a_q, dirty_b_q;
    logic [NUM_CH-1:0] pend_a_q, pend_b_q;
    logic [NUM_CH-1:0] written_q;
    logic rst_prev_q, seq_q;
    logic [$clog2(RESET_SEQ_CYC+1)-1:0] seq_cnt_q;
    logic [BW-1:0] busy_cnt_q;
    logic busy_line_q, load_pend_q, busy_seen_q;
    logic [NUM_CH-1:0] hit;

    // channels touched by one write: one, pair across groups, group, all
    function automatic logic [NUM_CH-1:0] ch_mask(duc_ch_mode_t m, logic [3:0] c);
        logic [NUM_CH-1:0] r;
        r = '0;
        unique case (m)
            DUC_CH_ONE: r[c] = 1'b1;
            DUC_CH_PAIR: begin
                r[{1'b0, c[2:0]}] = 1'b1;
                r[{1'b1, c[2:0]}] = 1'b1;
            end
            DUC_CH_GROUP: r = c[3] ? {{(NUM_CH/2){1'b1}}, {(NUM_CH/2){1'b0}}}
                                   : {{(NUM_CH/2){1'b0}}, {(NUM_CH/2){1'b1}}};
            DUC_CH_ALL: r = '1;
        endcase
        return r;
    endfunction

    // stand-in for the calibration arithmetic: x*(m+1)/2^n + c - 2^(n-1)
    function automatic logic [DATA_W-1:0] calc(logic [DATA_W-1:0] x, logic [DATA_W-1:0] m,
                                               logic [DATA_W-1:0] c);
        logic [2*DATA_W:0] p;
        p = ({{(DATA_W+1){1'b0}}, x} * ({1'b0, m} + 1'b1)) >> DATA_W;
        return DATA_W'(p[DATA_W-1:0] + c - (DATA_W'(1) << (DATA_W-1)));
    endfunction

    function automatic logic [BW-1:0] busy_len(duc_ch_mode_t m);
        int n;
        n = (m == DUC_CH_ONE) ? 1 : (m == DUC_CH_PAIR) ? 2 : (m == DUC_CH_GROUP) ? 8 : 16;
        return BW'((n + 1) * SLOT + TAIL);
    endfunction

    assign hit = ch_mask(wr_mode_i, wr_ch_i);
    wire wr_go = wr_valid_i && !seq_q;
    wire wr_calc = wr_go && (wr_kind_i != DUC_WR_SEL);
    wire line_free = link.busy_n;
    wire load_now = (load_pend_q || !link.load_outputs_n) && line_free && !busy_line_q
                    && link.output_clear_n && !seq_q;

    ////////////////////////////////////////////////////////////////////////
    // reset sequence on rising edge of reset pin
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_prev_q <= 1'b1;
            seq_q <= 1'b0;
            seq_cnt_q <= '0;
        end else begin
            rst_prev_q <= link.reset_n;
            if (link.reset_n && !rst_prev_q) begin
                seq_q <= 1'b1;
                seq_cnt_q <= '0;
            end else if (seq_q) begin
                seq_cnt_q <= seq_cnt_q + 1'b1;
                if (seq_cnt_q == $bits(seq_cnt_q)'(RESET_SEQ_CYC - 1)) begin
                    seq_q <= 1'b0;
                end
            end
        end
    end
    assign reset_busy_o = seq_q;

    ////////////////////////////////////////////////////////////////////////
    // register file, accepted even while busy
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                input_reg_a[i] <= `DUC_INPUT_RST;
                input_reg_b[i] <= `DUC_INPUT_RST;
                gain_a[i] <= `DUC_GAIN_RST;
                gain_b[i] <= `DUC_GAIN_RST;
                trim_a[i] <= `DUC_TRIM_RST;
                trim_b[i] <= `DUC_TRIM_RST;
            end
            src_sel_q <= `DUC_SEL_RST;
        end else if (seq_q && seq_cnt_q == '0) begin
            for (int i = 0; i < NUM_CH; i++) begin
                input_reg_a[i] <= `DUC_INPUT_RST;
                input_reg_b[i] <= `DUC_INPUT_RST;
                gain_a[i] <= `DUC_GAIN_RST;
                gain_b[i] <= `DUC_GAIN_RST;
                trim_a[i] <= `DUC_TRIM_RST;
                trim_b[i] <= `DUC_TRIM_RST;
            end
            src_sel_q <= `DUC_SEL_RST;
        end else if (wr_go) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (hit[i]) begin
                    unique case (wr_kind_i)
                        DUC_WR_INPUT: begin
                            if (wr_ab_sel_i) input_reg_b[i] <= wr_data_i;
                            else input_reg_a[i] <= wr_data_i;
                        end
                        DUC_WR_GAIN: begin
                            if (wr_ab_sel_i) gain_b[i] <= wr_data_i;
                            else gain_a[i] <= wr_data_i;
                        end
                        DUC_WR_TRIM: begin
                            if (wr_ab_sel_i) trim_b[i] <= wr_data_i;
                            else trim_a[i] <= wr_data_i;
                        end
                        DUC_WR_SEL: ;
                    endcase
                end
            end
            if (wr_kind_i == DUC_WR_SEL) begin
                // group write: channel bit 3 picks the half, data holds 8 select bits
                for (int i = 0; i < NUM_CH / 2; i++) begin
                    src_sel_q[{wr_ch_i[3], 3'(i)}] <= wr_data_i[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // recalculation requests; results appear when busy ends
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_a_q <= '0;
            pend_b_q <= '0;
        end else if (wr_calc) begin
            if (wr_ab_sel_i) pend_b_q <= pend_b_q | hit;
            else pend_a_q <= pend_a_q | hit;
        end else if (seq_q || busy_cnt_q == '0) begin
            // a reset sequence drops work queued before it
            pend_a_q <= '0;
            pend_b_q <= '0;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                computed_reg_a[i] <= `DUC_INPUT_RST;
                computed_reg_b[i] <= `DUC_INPUT_RST;
            end
            dirty_a_q <= '0;
            dirty_b_q <= '0;
        end else if (seq_q) begin
            // nothing counts as written after a reset sequence
            dirty_a_q <= '0;
            dirty_b_q <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                // results land on the last busy cycle so a stored load sees them
                if (busy_cnt_q == BW'(1) && !wr_calc && pend_a_q[i]) begin
                    computed_reg_a[i] <= calc(input_reg_a[i], gain_a[i], trim_a[i]);
                    dirty_a_q[i] <= 1'b1;
                end else if (load_now && !src_sel_q[i]) begin
                    dirty_a_q[i] <= 1'b0;
                end
                if (busy_cnt_q == BW'(1) && !wr_calc && pend_b_q[i]) begin
                    computed_reg_b[i] <= calc(input_reg_b[i], gain_b[i], trim_b[i]);
                    dirty_b_q[i] <= 1'b1;
                end else if (load_now && src_sel_q[i]) begin
                    dirty_b_q[i] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // own busy timer; each calculating write restarts the full span, a select write only raises it to one slot
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_cnt_q <= '0;
        end else if (wr_calc) begin
            busy_cnt_q <= busy_len(wr_mode_i);
        end else if (wr_go && busy_cnt_q < BW'(SLOT)) begin
            busy_cnt_q <= BW'(SLOT);
        end else if (busy_cnt_q != '0) begin
            busy_cnt_q <= busy_cnt_q - 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_line_q <= 1'b0;
        end else begin
            busy_line_q <= (busy_cnt_q > BW'(1)) || wr_go || seq_q;
        end
    end
    // open drain: enable low pulls the line low, else released
    assign link.busy_dev_oe_n = !busy_line_q;
    assign calc_busy_o = busy_line_q;

    ////////////////////////////////////////////////////////////////////////
    // load strobe memory while busy (ours or another device's)
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_seen_q <= 1'b0;
            load_pend_q <= 1'b0;
        end else begin
            busy_seen_q <= !line_free || busy_line_q;
            if (!link.output_clear_n || seq_q) begin
                load_pend_q <= 1'b0;
            end else if (!link.load_outputs_n && (!line_free || busy_line_q)) begin
                load_pend_q <= 1'b1;
            end else if (load_now) begin
                load_pend_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output registers; clear only masks the view, never the contents
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < NUM_CH; i++) out_q[i] <= `DUC_INPUT_RST;
            written_q <= '0;
        end else if (seq_q) begin
            written_q <= '0;
        end else if (load_now) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (!src_sel_q[i] && dirty_a_q[i]) begin
                    out_q[i] <= computed_reg_a[i];
                    written_q[i] <= 1'b1;
                end else if (src_sel_q[i] && dirty_b_q[i]) begin
                    out_q[i] <= computed_reg_b[i];
                    written_q[i] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_grounded_o <= '1;
            out_code_o <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                out_grounded_o[i] <= !link.output_clear_n || !written_q[i] || seq_q;
                out_code_o[i*DATA_W +: DATA_W] <= out_q[i];
            end
        end
    end
endmodule

/* File: logic/duc_host.sv */
`timescale 1ns/1ps
`include "duc_consts.svh"
module duc_host #(
    parameter int RESET_SEQ_CYC = `DUC_RESET_SEQ_CYC
) (
    input wire logic core_clk_i, // system clock
    input wire logic nrst_i, // async reset, active low
    duc_link_if.host link, // pins toward device
    input wire logic reset_req_i, // pulse: run a device reset
    input wire logic clear_i, // level: hold outputs at ground
    input wire logic span_change_i, // level: offset span being rewritten
    input wire logic load_req_i, // pulse: request an output load
    input wire logic load_hold_i, // level: keep load strobe low
    output logic write_ok_o, // writes allowed to device
    output logic busy_o // shared busy line seen low
);
    import duc_pkg::*;

    localparam int PW = `DUC_RST_PULSE_CYC;
    logic [$clog2(PW+2)-1:0] pulse_cnt_q;
    logic [$clog2(RESET_SEQ_CYC+1)-1:0] wait_cnt_q;
    logic rst_n_q, waiting_q, load_q;

    ////////////////////////////////////////////////////////////////////////
    // reset pulse, then keep writes off during the sequence
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_n_q <= 1'b0; // raised after one full pulse width once released
            pulse_cnt_q <= '0;
            waiting_q <= 1'b0;
            wait_cnt_q <= '0;
        end else if (reset_req_i && rst_n_q && !waiting_q) begin
            rst_n_q <= 1'b0;
            pulse_cnt_q <= '0;
        end else if (!rst_n_q) begin
            pulse_cnt_q <= pulse_cnt_q + 1'b1;
            if (pulse_cnt_q >= $bits(pulse_cnt_q)'(PW - 1)) begin
                rst_n_q <= 1'b1;
                waiting_q <= 1'b1;
                wait_cnt_q <= '0;
            end
        end else if (waiting_q) begin
            wait_cnt_q <= wait_cnt_q + 1'b1;
            if (wait_cnt_q == $bits(wait_cnt_q)'(RESET_SEQ_CYC)) begin
                waiting_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            load_q <= 1'b0;
        end else begin
            load_q <= load_req_i || load_hold_i;
        end
    end

    assign link.reset_n = rst_n_q;
    assign link.output_clear_n = !(clear_i || span_change_i);
    assign link.load_outputs_n = !load_q;
    assign link.busy_host_oe_n = 1'b1;
    assign write_ok_o = rst_n_q && !waiting_q;
    assign busy_o = !link.busy_n;
endmodule

/* File: tb/duc_link_asserts.sv */
`timescale 1ns/1ps
module duc_link_asserts #(
    parameter int RESET_SEQ_CYC = 50
) (
    input wire logic core_clk_i, // clock
    input wire logic nrst_i, // async reset
    input wire logic reset_n, // device reset pin
    input wire logic output_clear_n, // clear pin
    input wire logic load_outputs_n, // load pin
    input wire logic busy_dev_oe_n, // device pull-down enable
    input wire logic busy_host_oe_n, // host pull-down enable
    input wire logic busy_n, // shared busy line
    input wire logic reset_busy_o, // sequence running
    input wire logic calc_busy_o, // calculation running
    input wire logic [15:0] out_grounded_o, // outputs at ground
    input wire logic [255:0] out_code_o // output registers
);
    logic [15:0] rb_cnt_q;
    logic [11:0] bz_cnt_q;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rb_cnt_q <= '0;
        end else if (reset_busy_o) begin
            rb_cnt_q <= rb_cnt_q + 16'h0001;
        end else begin
            rb_cnt_q <= '0;
        end
    end

    // sequence time is kept out so a busy held through reset is not miscounted
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bz_cnt_q <= '0;
        end else if (busy_dev_oe_n || reset_busy_o || $past(reset_busy_o)) begin
            // the line trails the sequence by one cycle; that tail is not a pulse
            bz_cnt_q <= '0;
        end else begin
            bz_cnt_q <= bz_cnt_q + 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_clr_held;
        !output_clear_n [*3];
    endsequence
    sequence s_busy_on;
        !busy_n && !reset_busy_o;
    endsequence

    property p_rst_pulse;
        $fell(reset_n) |-> !reset_n [*3];
    endproperty
    property p_seq_start;
        $rose(reset_n) |-> ##[1:2] reset_busy_o;
    endproperty
    property p_seq_len;
        $fell(reset_busy_o) |-> rb_cnt_q >= RESET_SEQ_CYC - 1 && rb_cnt_q <= RESET_SEQ_CYC + 1;
    endproperty
    property p_seq_ground;
        $fell(reset_busy_o) |-> ##2 &out_grounded_o;
    endproperty
    property p_clr_ground;
        s_clr_held |-> &out_grounded_o;
    endproperty
    property p_clr_keep;
        s_clr_held |=> $stable(out_code_o);
    endproperty
    property p_busy_hold;
        s_busy_on |=> $stable(out_code_o);
    endproperty
    property p_busy_tie;
        calc_busy_o && $past(calc_busy_o) |-> !busy_n && !busy_dev_oe_n;
    endproperty
    property p_busy_len;
        $rose(busy_dev_oe_n) && bz_cnt_q != 0 |-> bz_cnt_q >= 59 && bz_cnt_q <= 1051;
    endproperty

    a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too short");
    a_seq_start: assert property (p_seq_start) else $error("sequence did not start");
    a_seq_len: assert property (p_seq_len) else $error("sequence length wrong");
    a_seq_ground: assert property (p_seq_ground) else $error("not grounded after reset");
    a_clr_ground: assert property (p_clr_ground) else $error("clear did not ground");
    a_clr_keep: assert property (p_clr_keep) else $error("output changed in clear");
    a_busy_hold: assert property (p_busy_hold) else $error("output changed while busy");
    a_busy_tie: assert property (p_busy_tie) else $error("busy line not pulled");
    a_busy_len: assert property (p_busy_len) else $error("busy width out of range");
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`include "duc_consts.svh"
module tb_top;
    import duc_pkg::*;
    localparam int SEQ = 50;
    logic core_clk_i, nrst_i, wr_valid, wr_ab;
    duc_wr_kind_t wr_kind;
    duc_ch_mode_t wr_mode;
    logic [3:0] wr_ch;
    logic [15:0] wr_data, grounded, old0, old1;
    logic reset_req, clear, span_chg, load_req, load_hold;
    logic reset_busy, calc_busy, write_ok, busy;
    logic [255:0] code;
    int err_count, checks;

    duc_link_if link();
    duc_device #(.RESET_SEQ_CYC(SEQ)) i_duc_device (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .link(link), .wr_valid_i(wr_valid), .wr_kind_i(wr_kind), .wr_ab_sel_i(wr_ab),
        .wr_mode_i(wr_mode), .wr_ch_i(wr_ch), .wr_data_i(wr_data), .reset_busy_o(reset_busy),
        .calc_busy_o(calc_busy), .out_grounded_o(grounded), .out_code_o(code));
    duc_host #(.RESET_SEQ_CYC(SEQ)) i_duc_host (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .link(link), .reset_req_i(reset_req), .clear_i(clear), .span_change_i(span_chg),
        .load_req_i(load_req), .load_hold_i(load_hold), .write_ok_o(write_ok), .busy_o(busy));
    duc_link_asserts #(.RESET_SEQ_CYC(SEQ)) i_duc_link_asserts (.core_clk_i(core_clk_i),
        .nrst_i(nrst_i), .reset_n(link.reset_n), .output_clear_n(link.output_clear_n),
        .load_outputs_n(link.load_outputs_n), .busy_dev_oe_n(link.busy_dev_oe_n),
        .busy_host_oe_n(link.busy_host_oe_n), .busy_n(link.busy_n),
        .reset_busy_o(reset_busy), .calc_busy_o(calc_busy), .out_grounded_o(grounded),
        .out_code_o(code));

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask

    task automatic wr(input duc_wr_kind_t k, input logic ab, input duc_ch_mode_t m,
                      input logic [3:0] ch, input logic [15:0] d);
        wr_kind = k;
        wr_ab = ab;
        wr_mode = m;
        wr_ch = ch;
        wr_data = d;
        wr_valid = 1'b1;
        cyc(1);
        wr_valid = 1'b0;
    endtask

    task automatic pulse_load;
        load_req = 1'b1;
        cyc(1);
        load_req = 1'b0;
    endtask

    // a stuck busy line must end the run rather than hang it
    task automatic wait_idle;
        int n;
        n = 0;
        while ((calc_busy !== 1'b0 || busy !== 1'b0 || write_ok !== 1'b1) && n < 3000) begin
            cyc(1);
            n++;
        end
        if (n == 3000) begin
            err_count++;
            $display("[ERR] idle wait expected 1 seen 0");
            final_report();
        end
        cyc(4);
    endtask

    task automatic busy_len(output int n);
        int w;
        w = 0;
        n = 0;
        while (calc_busy !== 1'b1 && w < 4) begin
            cyc(1);
            w++;
        end
        while (calc_busy === 1'b1 && n < 1200) begin
            cyc(1);
            n++;
        end
    endtask

    task automatic seq_run;
        int n;
        n = 0;
        while (reset_busy !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        chk("write_ok in sequence", 1'b0, write_ok);
        n = 0;
        while (reset_busy === 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        chk("sequence cycles", SEQ, n);
        wait_idle();
        chk("grounded after reset", 16'hffff, grounded);
        $display("reset sequence test done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_widths;
        int n;
        int nch[4] = '{1, 2, 8, 16};
        for (int i = 0; i < 4; i++) begin
            wr(DUC_WR_INPUT, 1'b0, duc_ch_mode_t'(i), 4'h0, 16'h8000);
            busy_len(n);
            chk("busy width", (nch[i] + 1) * `DUC_SLOT_CYC + `DUC_TAIL_CYC, n);
        end
        wr(DUC_WR_SEL, 1'b0, DUC_CH_GROUP, 4'h0, 16'h0000);
        busy_len(n);
        chk("select busy width", `DUC_SLOT_CYC, n);
        wait_idle();
        chk("grounded without load", 16'hffff, grounded);
        $display("busy width test done");
    endtask

    task automatic t_load_busy;
        pulse_load();
        wait_idle();
        old0 = code[15:0];
        old1 = code[31:16];
        wr(DUC_WR_INPUT, 1'b0, DUC_CH_ONE, 4'h0, 16'h1234);
        cyc(5);
        pulse_load();
        cyc(20);
        chk("ch0 held while busy", old0, code[15:0]);
        wait_idle();
        chk("ch0 loaded after busy", 1'b1, code[15:0] !== old0);
        chk("ch1 unchanged", old1, code[31:16]);
        chk("ch0 ungrounded", 1'b0, grounded[0]);
        $display("stored load test done");
    endtask

    task automatic t_clear;
        old0 = code[15:0];
        clear = 1'b1;
        cyc(4);
        chk("grounded in clear", 16'hffff, grounded);
        wr(DUC_WR_INPUT, 1'b0, DUC_CH_ONE, 4'h0, 16'h0f0f);
        wait_idle();
        pulse_load();
        cyc(4);
        chk("ch0 kept in clear", old0, code[15:0]);
        clear = 1'b0;
        cyc(4);
        chk("ch0 ungrounded", 1'b0, grounded[0]);
        chk("ch0 value back", old0, code[15:0]);
        span_chg = 1'b1;
        cyc(4);
        chk("grounded in span change", 16'hffff, grounded);
        span_chg = 1'b0;
        cyc(4);
        pulse_load();
        cyc(4);
        chk("ch0 loaded after clear", 1'b1, code[15:0] !== old0);
        $display("clear test done");
    endtask

    task automatic t_hold_ab;
        load_hold = 1'b1;
        old0 = code[15:0];
        wr(DUC_WR_INPUT, 1'b1, DUC_CH_ONE, 4'h0, 16'hbeef);
        wait_idle();
        chk("ch0 stays on a", old0, code[15:0]);
        wr(DUC_WR_SEL, 1'b0, DUC_CH_GROUP, 4'h0, 16'h0001);
        wait_idle();
        chk("ch0 takes b", 1'b1, code[15:0] !== old0);
        old0 = code[15:0];
        wr(DUC_WR_INPUT, 1'b0, DUC_CH_ONE, 4'h0, 16'h2222);
        wait_idle();
        chk("ch0 ignores a", old0, code[15:0]);
        load_hold = 1'b0;
        $display("held load test done");
    endtask

    task automatic t_reset;
        reset_req = 1'b1;
        cyc(1);
        reset_req = 1'b0;
        seq_run();
        pulse_load();
        cyc(4);
        chk("grounded load no write", 16'hffff, grounded);
        $display("reset pulse test done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst_i = 1'b0;
        wr_valid = 1'b0;
        wr_kind = DUC_WR_INPUT;
        wr_ab = 1'b0;
        wr_mode = DUC_CH_ONE;
        wr_ch = 4'h0;
        wr_data = 16'h0000;
        reset_req = 1'b0;
        clear = 1'b0;
        span_chg = 1'b0;
        load_req = 1'b0;
        load_hold = 1'b0;
        err_count = 0;
        checks = 0;
        cyc(16);
        nrst_i = 1'b1;
        seq_run();
        t_widths();
        t_load_busy();
        t_clear();
        t_hold_ab();
        t_reset();
        final_report();
    end
endmodule
